// [logic/usm_pkg.sv]
/*
  usm_pkg: shared constants for the uart status-flag and line-mode block.
  assumes: 8-bit register port driven by the chip's serial host front end.
*/
`default_nettype none
package usm_pkg;

  // =====================================================================
  // register offsets
  localparam logic [7:0] ADDR_STS_EN = 8'h07;
  localparam logic [7:0] ADDR_STS_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_MODE_A = 8'h09;

  // =====================================================================
  // reset values and writable bits
  localparam logic [7:0] STS_EN_RESET = 8'h00;
  localparam logic [7:0] STS_FLAGS_RESET = 8'h00;
  localparam logic [7:0] MODE_A_RESET = 8'h00;
  localparam logic [7:0] STS_EN_MASK = 8'hef;
  localparam logic [7:0] MODE_A_MASK = 8'h7f;

  // =====================================================================
  // field positions in status_irq_enable / status_irq_flags
  localparam int unsigned BIT_TX_DRAINED = 7;
  localparam int unsigned BIT_SLEEP = 6;
  localparam int unsigned BIT_CLOCK = 5;
  localparam int unsigned PIN_FLAGS = 4;
  localparam int unsigned PIN_GROUP_LSB_CH1 = 4;

  // =====================================================================
  // field positions in line_mode_ctrl_a
  localparam int unsigned BIT_AUTO_SLEEP = 6;
  localparam int unsigned BIT_FORCE_SLEEP = 5;
  localparam int unsigned BIT_AUTO_DIR = 4;
  localparam int unsigned BIT_RTS_FLOAT = 3;
  localparam int unsigned BIT_TX_FLOAT = 2;
  localparam int unsigned BIT_TX_INHIBIT = 1;
  localparam int unsigned BIT_RX_INHIBIT = 0;

  // =====================================================================
  // idle time before auto sleep, in clock cycles
  localparam logic [11:0] AUTO_SLEEP_CYCLES = 12'hfa0;

  // auto direction control states
  typedef enum logic [1:0] {
    DIR_RX = 2'b00,
    DIR_SETUP = 2'b01,
    DIR_SEND = 2'b10,
    DIR_HOLD = 2'b11
  } usm_dir_t;

endpackage
`default_nettype wire

// [logic/usm_pin_watch.sv]
/*
  usm_pin_watch: change-of-level detector for the four pins of one channel.
  assumes: pin levels are synchronous to ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module usm_pin_watch (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] pins_i,
  input wire logic [3:0] enable_i,
  output logic [3:0] change_o
);

  typedef struct packed {
    logic [3:0] last;
  } usm_watch_t;

  usm_watch_t st_ff;
  usm_watch_t nxt_st;

  // =====================================================================
  // level history, kept even while disabled so enabling never fires falsely
  always_comb begin
    nxt_st = st_ff;
    nxt_st.last = pins_i;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // a change only counts for an enabled pin
  assign change_o = (pins_i ^ st_ff.last) & enable_i;

endmodule
`default_nettype wire

// [logic/usm_status_mode.sv]
/*
  usm_status_mode: per-channel status flags, their routing enables and the
  first line-mode register (sleep, auto direction, pin floating, inhibits).
  assumes: register strobes come from the serial host front end, one cycle
  each; transmitter, receiver, clock unit and gpio pins live outside.
*/
`timescale 1ns/1ps
`default_nettype none
module usm_status_mode #(
  parameter bit CHAN = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic tx_fifo_empty_i,
  input wire logic tx_busy_i,
  input wire logic tx_serial_i,
  input wire logic bit_tick_i,
  input wire logic [7:0] half_duplex_delay_i,
  input wire logic rts_manual_i,
  input wire logic activity_i,
  input wire logic clock_enabled_i,
  input wire logic clock_settled_i,
  input wire logic xtal_mode_i,
  input wire logic [7:0] gpio_pins_i,
  output logic tx_start_allow_o,
  output logic tx_o,
  output logic tx_oe_n_o,
  output logic rts_o,
  output logic rts_oe_n_o,
  output logic rx_inhibit_o,
  output logic sleep_o,
  output logic tx_empty_event_o,
  output logic status_summary_o
);

  // =====================================================================
  // state
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] flags;
    logic [7:0] mode;
    logic [7:0] rdata;
    logic [11:0] idle_cnt;
    logic auto_asleep;
    logic asleep;
    logic tx_done;
    logic fifo_empty;
    usm_pkg::usm_dir_t dir;
    logic [3:0] dly_cnt;
    logic rts;
    logic tx;
    logic empty_event;
  } usm_state_t;

  usm_state_t st_ff;
  usm_state_t nxt_st;

  logic [3:0] pin_change;
  logic tx_done_now;
  logic tx_done_rise;
  logic asleep_now;
  logic rd_flags;
  logic auto_dir;

  // =====================================================================
  // helpers
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] want);
    hit = (addr == want);
  endfunction

  function automatic logic [3:0] step_down(input logic [3:0] cnt, input logic tick);
    step_down = (tick && cnt != 4'h0) ? cnt - 4'h1 : cnt;
  endfunction

  // =====================================================================
  // pin change detection for this channel's group
  usm_pin_watch u_pin_watch (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .pins_i(gpio_pins_i[(CHAN ? usm_pkg::PIN_GROUP_LSB_CH1 : 0) +: usm_pkg::PIN_FLAGS]),
    .enable_i(st_ff.en[3:0]),
    .change_o(pin_change)
  );

  // shared terms
  assign auto_dir = st_ff.mode[usm_pkg::BIT_AUTO_DIR];
  assign tx_done_now = tx_fifo_empty_i && !tx_busy_i;
  assign tx_done_rise = tx_done_now && !st_ff.tx_done;
  assign asleep_now = st_ff.mode[usm_pkg::BIT_FORCE_SLEEP] || st_ff.auto_asleep;
  assign rd_flags = reg_rd_i && hit(reg_addr_i, usm_pkg::ADDR_STS_FLAGS);

  // =====================================================================
  // next-state logic
  always_comb begin
    logic [7:0] set_v;
    logic [7:0] clr_v;
    set_v = 8'h00;
    clr_v = 8'h00;
    nxt_st = st_ff;

    // register writes
    if (reg_wr_i && hit(reg_addr_i, usm_pkg::ADDR_STS_EN)) begin
      nxt_st.en = reg_wdata_i & usm_pkg::STS_EN_MASK;
    end
    if (reg_wr_i && hit(reg_addr_i, usm_pkg::ADDR_MODE_A)) begin
      nxt_st.mode = reg_wdata_i & usm_pkg::MODE_A_MASK;
    end

    // auto sleep: idle counter runs while nothing happens
    if (!st_ff.mode[usm_pkg::BIT_AUTO_SLEEP] || activity_i || !tx_fifo_empty_i) begin
      nxt_st.idle_cnt = 12'h000;
      nxt_st.auto_asleep = 1'b0;
    end else if (st_ff.idle_cnt == usm_pkg::AUTO_SLEEP_CYCLES) begin
      nxt_st.auto_asleep = 1'b1;
    end else begin
      nxt_st.idle_cnt = st_ff.idle_cnt + 12'h001;
    end
    nxt_st.asleep = asleep_now;

    // flag set terms
    set_v[usm_pkg::BIT_TX_DRAINED] = tx_done_rise;
    set_v[usm_pkg::BIT_SLEEP] = asleep_now && !st_ff.asleep && clock_enabled_i;
    set_v[usm_pkg::BIT_CLOCK] = clock_settled_i && xtal_mode_i && clock_enabled_i;
    set_v[3:0] = pin_change;

    // flag clear terms: status read hits drained and pin flags only
    if (rd_flags) begin
      clr_v[usm_pkg::BIT_TX_DRAINED] = 1'b1;
      clr_v[3:0] = 4'hf;
    end
    clr_v[usm_pkg::BIT_SLEEP] = !asleep_now || !clock_enabled_i;
    clr_v[usm_pkg::BIT_CLOCK] = !clock_enabled_i;

    // a set in the clearing cycle wins
    nxt_st.flags = (st_ff.flags & ~clr_v) | set_v;

    nxt_st.tx_done = tx_done_now;
    nxt_st.fifo_empty = tx_fifo_empty_i;
    nxt_st.empty_event = auto_dir && tx_fifo_empty_i && !st_ff.fifo_empty;

    // auto direction control
    if (!auto_dir) begin
      nxt_st.dir = usm_pkg::DIR_RX;
      nxt_st.dly_cnt = 4'h0;
    end else begin
      unique case (st_ff.dir)
        usm_pkg::DIR_RX: begin
          if (!tx_fifo_empty_i) begin
            nxt_st.dir = usm_pkg::DIR_SETUP;
            nxt_st.dly_cnt = half_duplex_delay_i[7:4];
          end
        end
        usm_pkg::DIR_SETUP: begin
          if (st_ff.dly_cnt == 4'h0) begin
            nxt_st.dir = usm_pkg::DIR_SEND;
          end else begin
            nxt_st.dly_cnt = step_down(st_ff.dly_cnt, bit_tick_i);
          end
        end
        usm_pkg::DIR_SEND: begin
          if (tx_done_now) begin
            nxt_st.dir = usm_pkg::DIR_HOLD;
            nxt_st.dly_cnt = half_duplex_delay_i[3:0];
          end
        end
        usm_pkg::DIR_HOLD: begin
          if (!tx_fifo_empty_i) begin
            nxt_st.dir = usm_pkg::DIR_SEND;
          end else if (st_ff.dly_cnt == 4'h0) begin
            nxt_st.dir = usm_pkg::DIR_RX;
          end else begin
            nxt_st.dly_cnt = step_down(st_ff.dly_cnt, bit_tick_i);
          end
        end
      endcase
    end

    // pin levels
    nxt_st.rts = auto_dir ? (st_ff.dir != usm_pkg::DIR_RX) : rts_manual_i;
    nxt_st.tx = tx_busy_i ? tx_serial_i : 1'b1;

    // read data
    nxt_st.rdata = st_ff.rdata;
    if (reg_rd_i) begin
      if (hit(reg_addr_i, usm_pkg::ADDR_STS_EN)) begin
        nxt_st.rdata = st_ff.en;
      end else if (hit(reg_addr_i, usm_pkg::ADDR_STS_FLAGS)) begin
        nxt_st.rdata = st_ff.flags;
      end else if (hit(reg_addr_i, usm_pkg::ADDR_MODE_A)) begin
        nxt_st.rdata = st_ff.mode;
        nxt_st.rdata[usm_pkg::BIT_FORCE_SLEEP] = asleep_now;
        nxt_st.rdata[usm_pkg::BIT_TX_INHIBIT] = st_ff.mode[usm_pkg::BIT_TX_INHIBIT]
          || (auto_dir && tx_done_now);
      end else begin
        nxt_st.rdata = 8'h00;
      end
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '{
        en: usm_pkg::STS_EN_RESET,
        flags: usm_pkg::STS_FLAGS_RESET,
        mode: usm_pkg::MODE_A_RESET,
        rdata: 8'h00,
        idle_cnt: 12'h000,
        auto_asleep: 1'b0,
        asleep: 1'b0,
        tx_done: 1'b1,
        fifo_empty: 1'b1,
        dir: usm_pkg::DIR_RX,
        dly_cnt: 4'h0,
        rts: 1'b0,
        tx: 1'b1,
        empty_event: 1'b0
      };
    end else begin
      st_ff <= nxt_st;
    end
  end

  // =====================================================================
  // outputs
  assign reg_rdata_o = st_ff.rdata;
  assign status_summary_o = |(st_ff.flags & st_ff.en);
  assign tx_start_allow_o = !st_ff.mode[usm_pkg::BIT_TX_INHIBIT] && !st_ff.asleep
    && (!auto_dir || st_ff.dir == usm_pkg::DIR_SEND);
  assign tx_o = st_ff.tx;
  assign tx_oe_n_o = st_ff.mode[usm_pkg::BIT_TX_FLOAT];
  assign rts_o = st_ff.rts;
  assign rts_oe_n_o = st_ff.mode[usm_pkg::BIT_RTS_FLOAT];
  assign rx_inhibit_o = st_ff.mode[usm_pkg::BIT_RX_INHIBIT];
  assign sleep_o = st_ff.asleep;
  assign tx_empty_event_o = st_ff.empty_event;

  // =====================================================================
  // checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence s_force_write;
    reg_wr_i && hit(reg_addr_i, usm_pkg::ADDR_MODE_A) && reg_wdata_i[usm_pkg::BIT_FORCE_SLEEP];
  endsequence

  sequence s_then_asleep;
    ##2 sleep_o;
  endsequence

  sequence s_rts_request;
    auto_dir && st_ff.dir == usm_pkg::DIR_RX && !tx_fifo_empty_i;
  endsequence

  AST_SUMMARY_OR: assert property (
    status_summary_o == ((st_ff.flags[7] && st_ff.en[7]) || (st_ff.flags[6] && st_ff.en[6])
      || (st_ff.flags[5] && st_ff.en[5]) || |(st_ff.flags[3:0] & st_ff.en[3:0])))
    else $error("summary bit disagrees with routed flags");

  AST_PIN_GATED: assert property (
    ((st_ff.flags[3:0] & ~$past(st_ff.flags[3:0]) & ~$past(st_ff.en[3:0])) == 4'h0))
    else $error("pin flag set while its enable was low");

  AST_READ_CLEARS: assert property (
    (rd_flags && !tx_done_rise && pin_change == 4'h0) |=> (!st_ff.flags[7] && st_ff.flags[3:0] == 4'h0))
    else $error("status read did not clear drained and pin flags");

  AST_SLEEP_FLAG_HELD: assert property (
    st_ff.flags[6] |-> st_ff.asleep)
    else $error("sleep flag set while awake");

  AST_SLEEP_SURVIVES_READ: assert property (
    (rd_flags && st_ff.flags[6] && asleep_now && clock_enabled_i) |=> st_ff.flags[6])
    else $error("status read cleared the sleep flag");

  AST_CLOCK_OFF_CLEARS: assert property (
    (!clock_enabled_i) |=> !st_ff.flags[5])
    else $error("clock flag survived clock disable");

  AST_FORCE_SLEEP: assert property (
    s_force_write ##1 (st_ff.mode[usm_pkg::BIT_FORCE_SLEEP] && !reg_wr_i) |-> ##1 sleep_o)
    else $error("forced sleep not entered");

  AST_FORCE_SLEEP_DELAY: assert property (
    (s_force_write ##1 !reg_wr_i) |-> ##1 sleep_o)
    else $error("forced sleep took too long");

  AST_RTS_RAISE: assert property (
    s_rts_request |=> (st_ff.dir == usm_pkg::DIR_SETUP) ##1 rts_o)
    else $error("rts not raised for queued data");

  AST_RTS_LOW_EMPTY: assert property (
    (auto_dir && st_ff.dir == usm_pkg::DIR_RX) |=> !rts_o)
    else $error("rts high while receiving");

  AST_TX_HOLD: assert property (
    st_ff.mode[usm_pkg::BIT_TX_INHIBIT] |-> !tx_start_allow_o)
    else $error("transmit start allowed while inhibited");

  AST_TX_IDLE_HIGH: assert property (
    (!tx_busy_i) |=> tx_o)
    else $error("tx not idle high with shifter idle");

  AST_DRAINED_SET: assert property (
    tx_done_rise |=> st_ff.flags[usm_pkg::BIT_TX_DRAINED])
    else $error("drained flag not set after transmitter emptied");

  AST_SLEEP_READBACK: assert property (
    (reg_rd_i && hit(reg_addr_i, usm_pkg::ADDR_MODE_A))
      |=> (reg_rdata_o[usm_pkg::BIT_FORCE_SLEEP] == $past(asleep_now)))
    else $error("mode readback does not show the sleep state");

  AST_RTS_SEND_HIGH: assert property (
    (auto_dir && st_ff.dir == usm_pkg::DIR_SEND) |=> rts_o)
    else $error("rts low while sending");

  AST_EMPTY_EVENT_PULSE: assert property (
    tx_empty_event_o |=> !tx_empty_event_o)
    else $error("fifo-empty event longer than one cycle");

endmodule
`default_nettype wire

// [testbench/usm_tx_model.sv]
/*
  usm_tx_model: behavioural transmit fifo and shifter facing usm_status_mode.
  assumes: one clock; add_i queues two characters per pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module usm_tx_model (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic start_allow_i,
  input wire logic add_i,
  output logic fifo_empty_o,
  output logic busy_o,
  output logic serial_o,
  output logic tick_o
);
  // ======================================================================
  // fifo count, bit timer and shifter
  logic [1:0] div_ff;
  logic [3:0] chars_ff;
  logic [3:0] bits_ff;
  logic start_now;

  // bit tick every fourth cycle, serial toggles per bit while busy
  assign tick_o = (div_ff == 2'h3);
  assign fifo_empty_o = (chars_ff == 4'h0);
  assign serial_o = busy_o ? bits_ff[0] : 1'b1;
  assign start_now = !busy_o && chars_ff != 4'h0 && start_allow_i;

  // a character starts only when the block allows it, ten bit times long
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_ff <= 2'h0;
      chars_ff <= 4'h0;
      bits_ff <= 4'h0;
      busy_o <= 1'b0;
    end else begin
      div_ff <= div_ff + 2'h1;
      chars_ff <= chars_ff + (add_i ? 4'h2 : 4'h0) - (start_now ? 4'h1 : 4'h0);
      if (start_now) begin
        busy_o <= 1'b1;
        bits_ff <= 4'ha;
      end else if (busy_o && tick_o) begin
        bits_ff <= bits_ff - 4'h1;
        if (bits_ff == 4'h1) begin
          busy_o <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
/*
  testbench: register sequences against usm_status_mode, channel zero.
  assumes: rules are also asserted inside the design; 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ======================================================================
  // signals
  logic ref_clk_i, reset_n_i, reg_wr_i, reg_rd_i, activity_i, add_i;
  logic clock_enabled_i, clock_settled_i, xtal_mode_i, rts_manual_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, half_duplex_delay_i, gpio_pins_i, rd_v;
  logic fifo_empty, busy, serial, tick, allow, tx_o, tx_oe_n, rts_o, rts_oe_n, rx_inh, sleep_o, ev, summary;
  int failures, checks, cycles, events, i;

  usm_status_mode #(.CHAN(1'b0)) dut_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .tx_fifo_empty_i(fifo_empty), .tx_busy_i(busy), .tx_serial_i(serial),
    .bit_tick_i(tick), .half_duplex_delay_i(half_duplex_delay_i), .rts_manual_i(rts_manual_i),
    .activity_i(activity_i), .clock_enabled_i(clock_enabled_i), .clock_settled_i(clock_settled_i),
    .xtal_mode_i(xtal_mode_i), .gpio_pins_i(gpio_pins_i), .tx_start_allow_o(allow), .tx_o(tx_o),
    .tx_oe_n_o(tx_oe_n), .rts_o(rts_o), .rts_oe_n_o(rts_oe_n), .rx_inhibit_o(rx_inh),
    .sleep_o(sleep_o), .tx_empty_event_o(ev), .status_summary_o(summary));

  usm_tx_model model_u (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .start_allow_i(allow),
    .add_i(add_i), .fifo_empty_o(fifo_empty), .busy_o(busy), .serial_o(serial), .tick_o(tick));

  // ======================================================================
  // clock, timeout and event counting
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    cycles++;
    if (ev === 1'b1) events++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // ======================================================================
  // tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd_v = reg_rdata_o;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ======================================================================
  // main sequence
  initial begin
    {reset_n_i, reg_wr_i, reg_rd_i, add_i, rts_manual_i, clock_settled_i, xtal_mode_i} = 7'h00;
    {activity_i, clock_enabled_i} = 2'b11;
    {reg_addr_i, reg_wdata_i, gpio_pins_i} = 24'h000000;
    half_duplex_delay_i = 8'h21;
    {failures, checks, cycles, events} = 0;
    cyc(16);
    reset_n_i <= 1'b1;
    // reset values, reserved bits and an unmapped offset
    for (i = 7; i < 11; i++) begin
      rd(i[7:0]);
      check("reset read", rd_v, 8'h00);
    end
    wr(8'h07, 8'hff);
    rd(8'h07);
    check("enable mask", rd_v, 8'hef);
    wr(8'h09, 8'h80);
    rd(8'h09);
    check("mode bit7", rd_v, 8'h00);
    // pin change flags: gated, mapped to low pins, read clears
    wr(8'h07, 8'h05);
    @(posedge ref_clk_i) gpio_pins_i <= 8'hff;
    cyc(3);
    check("summary pins", {7'h00, summary}, 8'h01);
    rd(8'h08);
    check("pin flags", rd_v, 8'h05);
    rd(8'h08);
    check("pin flags cleared", rd_v, 8'h00);
    check("summary idle", {7'h00, summary}, 8'h00);
    wr(8'h07, 8'h0f);
    @(posedge ref_clk_i) gpio_pins_i <= 8'h0f;
    cyc(3);
    rd(8'h08);
    check("upper pins ignored", rd_v, 8'h00);
    // clock settled flag: crystal mode only, not read cleared, routed by bit5
    @(posedge ref_clk_i) clock_settled_i <= 1'b1;
    cyc(3);
    rd(8'h08);
    check("clock external", rd_v, 8'h00);
    @(posedge ref_clk_i) xtal_mode_i <= 1'b1;
    wr(8'h07, 8'h00);
    cyc(3);
    check("summary unrouted", {7'h00, summary}, 8'h00);
    rd(8'h08);
    rd(8'h08);
    check("clock flag kept", rd_v, 8'h20);
    wr(8'h07, 8'h20);
    check("summary clock", {7'h00, summary}, 8'h01);
    // forced sleep and its flag
    wr(8'h09, 8'h20);
    cyc(2);
    check("sleep out", {7'h00, sleep_o}, 8'h01);
    rd(8'h09);
    check("sleep readback", rd_v, 8'h20);
    rd(8'h08);
    rd(8'h08);
    check("sleep flag kept", rd_v, 8'h60);
    wr(8'h07, 8'h40);
    check("summary sleep", {7'h00, summary}, 8'h01);
    wr(8'h09, 8'h00);
    cyc(3);
    rd(8'h08);
    check("sleep flag exit", rd_v, 8'h20);
    check("summary after exit", {7'h00, summary}, 8'h00);
    @(posedge ref_clk_i) clock_enabled_i <= 1'b0;
    cyc(3);
    rd(8'h08);
    check("clock off", rd_v, 8'h00);
    @(posedge ref_clk_i) clock_enabled_i <= 1'b1;
    // pin floating and receive inhibit
    wr(8'h09, 8'h0d);
    cyc(2);
    check("float and inhibit", {5'h00, tx_oe_n, rts_oe_n, rx_inh}, 8'h07);
    // transmit inhibit holds characters in the fifo, tx idles high
    wr(8'h09, 8'h02);
    @(posedge ref_clk_i) add_i <= 1'b1;
    @(posedge ref_clk_i) add_i <= 1'b0;
    cyc(60);
    check("inhibited tx", {4'h0, allow, busy, fifo_empty, tx_o}, 8'h01);
    wr(8'h09, 8'h00);
    for (i = 0; i < 400 && !(fifo_empty && !busy); i++) @(posedge ref_clk_i);
    cyc(3);
    rd(8'h08);
    check("drained flag", rd_v, 8'ha0);
    rd(8'h08);
    check("drained cleared", rd_v, 8'h20);
    // auto direction: rts frames the transfer, empty event once
    wr(8'h09, 8'h10);
    rd(8'h09);
    check("inhibit reads empty", rd_v, 8'h12);
    events = 0;
    @(posedge ref_clk_i) add_i <= 1'b1;
    @(posedge ref_clk_i) add_i <= 1'b0;
    for (i = 0; i < 200 && !busy; i++) @(posedge ref_clk_i);
    check("rts before send", {7'h00, rts_o}, 8'h01);
    for (i = 0; i < 400 && !(fifo_empty && !busy); i++) @(posedge ref_clk_i);
    cyc(30);
    check("rts after send", {7'h00, rts_o}, 8'h00);
    check("empty event", events[7:0], 8'h01);
    // auto sleep after the idle time
    rd(8'h08);
    wr(8'h09, 8'h40);
    @(posedge ref_clk_i) activity_i <= 1'b0;
    for (i = 0; i < 4100 && !sleep_o; i++) @(posedge ref_clk_i);
    check("auto sleep time", {7'h00, i > 3990 && i < 4010}, 8'h01);
    cyc(2);
    rd(8'h08);
    check("auto sleep flag", rd_v & 8'h40, 8'h40);
    rd(8'h09);
    check("auto sleep readback", rd_v, 8'h60);
    report_and_stop();
  end
endmodule
`default_nettype wire
